// [verilog/dma_stream_core.sv]
// Purpose: stream dma core, NC controllers of eight streams each
// Assumes: avalon-mm slave with waitrequest, ahb-lite masters, one clock
// Notes: one beat in flight per controller; bursts run as single beats
//
// Added by the designer: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "dma_cfg.svh"
// Functional notes
// - peripheral-side data for a request moves only after the stream has taken that request
// - NC controllers, eight streams each, each stream with its own request lines
// - five sticky flags per stream, settable by software too
// - a three-bit channel field picks one of eight request inputs
// - arbiter ranks wanting streams by four software priority levels
// - equal priority goes to the lowest stream number
// - every stream owns its own four-word fifo
// - fifo threshold is a quarter, half, three quarters or full
// - direct mode moves one item per peripheral request at once
// - direct memory-to-peripheral prefetches one item, written on request
// - direct mode needs equal widths, no bursts, no memory-to-memory
// - p2m and m2m fifo mode drains to destination once threshold is reached
// - separate memory-side and peripheral-side bus master ports
// - first controller cannot do memory-to-memory over its ports
// - second controller has three directions, first only two
// - direction comes from the stream configuration register
// - increment bits advance each side's address by its item size
// - item size fields select byte, half-word or word
// - circular mode reloads the item count and carries on
// - bursts only on a side whose address increments
module dma_stream_core import dma_pkg::*; #(
   parameter int NC = 2,
   parameter int NS = 8,
   parameter int NCH = 8,
   parameter int FD = 4
) (
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [10:0] AVS_ADDRESS_IN,
   input wire logic AVS_READ_IN,
   input wire logic AVS_WRITE_IN,
   input wire logic [31:0] AVS_WRITEDATA_IN,
   input wire logic [3:0] AVS_BYTEENABLE_IN,
   output logic [31:0] AVS_READDATA_OUT,
   output logic AVS_WAITREQUEST_OUT,
   input wire logic [NC*NS*NCH-1:0] PREQ_IN,
   output logic [NC*NS-1:0] PACK_OUT,
   output ahb_m_t [NC-1:0] MEM_M_OUT,
   input wire ahb_s_t [NC-1:0] MEM_S_IN,
   output ahb_m_t [NC-1:0] PER_M_OUT,
   input wire ahb_s_t [NC-1:0] PER_S_IN
);
   localparam int LW = $clog2(FD + 1);
   localparam int PW = $clog2(FD);

   if (NC < 1 || NC > 2 || NS != 8 || NCH != 8 || FD < 4 || (FD & (FD - 1)) != 0)
   begin : g_bad
      $error("unsupported dma_stream_core parameters");
   end

   function automatic logic [6:0] dec(input logic [9:0] off);
      logic [9:0] rel;
      dec = 7'h00;
      for (int s = 0; s < 8; s++) begin
         rel = off - (`OFF_STRM0 + `STRM_STRIDE * 10'(s));
         if (rel < `STRM_STRIDE) dec = {1'b1, 3'(s), rel[4:2]};
      end
   endfunction : dec

   function automatic logic [4:0] fpos(input logic [1:0] q);
      case (q)
         2'h0: fpos = 5'd0;
         2'h1: fpos = 5'd6;
         2'h2: fpos = 5'd16;
         default: fpos = 5'd22;
      endcase
   endfunction : fpos

   function automatic logic [31:0] lane_rd(input logic [31:0] d, input logic [1:0] a,
                                           input logic [1:0] sz);
      logic [31:0] x;
      x = d >> {a, 3'b000};
      case (sz)
         2'h0: lane_rd = {24'h0, x[7:0]};
         2'h1: lane_rd = {16'h0, x[15:0]};
         default: lane_rd = x;
      endcase
   endfunction : lane_rd

   function automatic logic [31:0] lane_wr(input logic [31:0] d, input logic [1:0] sz);
      case (sz)
         2'h0: lane_wr = {4{d[7:0]}};
         2'h1: lane_wr = {2{d[15:0]}};
         default: lane_wr = d;
      endcase
   endfunction : lane_wr

   logic [31:0] cfg_q [NC][NS];
   logic [31:0] fc_q [NC][NS];
   logic [31:0] pbase_q [NC][NS];
   logic [31:0] mbase_q [NC][NS];
   logic [31:0] pcur_q [NC][NS];
   logic [31:0] mcur_q [NC][NS];
   logic [15:0] nini_q [NC][NS];
   logic [15:0] nleft_q [NC][NS];
   logic [15:0] rleft_q [NC][NS];
   logic [31:0] fifo_q [NC][NS][FD];
   logic [LW-1:0] lvl_q [NC][NS];
   logic [PW-1:0] wp_q [NC][NS];
   logic [PW-1:0] rp_q [NC][NS];
   logic [5:0] flg_q [NC][NS];
   logic pend_q [NC][NS];
   logic prev_q [NC][NS];
   eng_state_t st_q [NC];
   logic [2:0] es_q [NC];
   logic ew_q [NC];
   logic pm_q [NC];
   logic [NC-1:0] done;
   logic [NC-1:0] err;
   logic [31:0] rdv [NC];

   // avalon slave: one wait cycle, then readdata from a flop
   logic wait_q;
   logic [31:0] rd_d;
   logic [63:0] sts;
   wire acc = (AVS_READ_IN | AVS_WRITE_IN) & wait_q;
   wire wr_acc = AVS_WRITE_IN & wait_q;
   wire ac = AVS_ADDRESS_IN[10];
   wire ctl_ok = 32'(ac) < NC;
   wire [9:0] off = AVS_ADDRESS_IN[9:0];
   wire [6:0] dcd = dec(off);
   wire [31:0] wmask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                        {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};

   always_comb begin
      rd_d = 32'h0;
      sts = 64'h0;
      for (int s = 0; s < 8; s++) sts[32 * (s / 4) + 32'(fpos(2'(s))) +: 6] = flg_q[ac][s];
      if (ctl_ok && dcd[6]) begin
         case (dcd[2:0])
            `FLD_CFG: rd_d = cfg_q[ac][dcd[5:3]];
            `FLD_NDATA: rd_d = {16'h0, nleft_q[ac][dcd[5:3]]};
            `FLD_PADDR: rd_d = pbase_q[ac][dcd[5:3]];
            `FLD_MADDR: rd_d = mbase_q[ac][dcd[5:3]];
            `FLD_FCTRL: rd_d = fc_q[ac][dcd[5:3]] | (32'(lvl_q[ac][dcd[5:3]]) << `FC_LVL);
            default: rd_d = 32'h0;
         endcase
      end else if (ctl_ok && off == `OFF_LSTS) begin
         rd_d = sts[31:0];
      end else if (ctl_ok && off == `OFF_HSTS) begin
         rd_d = sts[63:32];
      end
   end

   always_ff @(posedge CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         wait_q <= 1'b1;
         AVS_READDATA_OUT <= 32'h0;
      end else begin
         wait_q <= ~acc;
         if (acc) AVS_READDATA_OUT <= rd_d;
      end
   end
   assign AVS_WAITREQUEST_OUT = wait_q;

   for (genvar c = 0; c < NC; c++) begin : g_ctl
      logic [7:0] want;
      logic [7:0] wwr;
      logic [15:0] prs;
      logic [3:0] pk;
      logic hi_win;
      logic lo_tie;
      ahb_s_t sin;
      ahb_m_t beat;
      wire [2:0] ps = pk[2:0];
      wire [1:0] pdir = cfg_q[c][ps][`CFG_DIR +: 2];
      // memory port serves m2p reads and p2m/m2m writes
      wire pmx = wwr[ps] ? (pdir != `DIR_M2P) : (pdir == `DIR_M2P);
      wire [1:0] psz = pmx ? cfg_q[c][ps][`CFG_MSIZE +: 2] : cfg_q[c][ps][`CFG_PSIZE +: 2];
      wire ahb_m_t cur = pm_q[c] ? MEM_M_OUT[c] : PER_M_OUT[c];

      always_comb begin
         pk = 4'h0;
         for (int s = 0; s < 8; s++)
            if (want[s] && (!pk[3] || prs[2 * s +: 2] > prs[2 * pk[2:0] +: 2]))
               pk = {1'b1, 3'(s)};
         hi_win = 1'b0;
         lo_tie = 1'b0;
         for (int s = 0; s < 8; s++) begin
            // read the winner from pk, not ps, so the process never loops on itself
            if (want[s] && prs[2 * s +: 2] > prs[2 * pk[2:0] +: 2]) hi_win = 1'b1;
            if (want[s] && s < 32'(pk[2:0]) && prs[2 * s +: 2] == prs[2 * pk[2:0] +: 2])
               lo_tie = 1'b1;
         end
      end

      assign beat = '{htrans: `HTRANS_NONSEQ, haddr: pmx ? mcur_q[c][ps] : pcur_q[c][ps],
                      hwrite: wwr[ps], hsize: {1'b0, psz},
                      hwdata: lane_wr(fifo_q[c][ps][rp_q[c][ps]], psz)};
      assign sin = pm_q[c] ? MEM_S_IN[c] : PER_S_IN[c];
      assign done[c] = st_q[c] == E_DATA && sin.hready;
      assign err[c] = sin.hresp;
      assign rdv[c] = lane_rd(sin.hrdata, cur.haddr[1:0], cur.hsize[1:0]);

      always_ff @(posedge CLK_IN or negedge NRST_IN) begin
         if (!NRST_IN) begin
            st_q[c] <= E_IDLE;
            es_q[c] <= 3'h0;
            ew_q[c] <= 1'b0;
            pm_q[c] <= 1'b0;
            MEM_M_OUT[c] <= '0;
            PER_M_OUT[c] <= '0;
         end else begin
            case (st_q[c])
               E_IDLE: if (pk[3]) begin
                  st_q[c] <= E_ADDR;
                  es_q[c] <= ps;
                  ew_q[c] <= wwr[ps];
                  pm_q[c] <= pmx;
                  if (pmx) MEM_M_OUT[c] <= beat;
                  else PER_M_OUT[c] <= beat;
               end
               E_ADDR: begin
                  st_q[c] <= E_DATA;
                  MEM_M_OUT[c].htrans <= `HTRANS_IDLE;
                  PER_M_OUT[c].htrans <= `HTRANS_IDLE;
               end
               E_DATA: if (sin.hready) st_q[c] <= E_IDLE;
               default: st_q[c] <= E_IDLE;
            endcase
         end
      end

      arb_rank_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
         (st_q[c] == E_IDLE && pk[3]) |-> !hi_win) else $error("lower priority won");
      arb_tie_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
         (st_q[c] == E_IDLE && pk[3]) |-> !lo_tie) else $error("higher stream won tie");
      ahb_hold_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
         (st_q[c] == E_DATA && !sin.hready) |=> st_q[c] == E_DATA && $stable(MEM_M_OUT[c])
         && $stable(PER_M_OUT[c])) else $error("bus outputs moved in wait");

      for (genvar s = 0; s < NS; s++) begin : g_str
         wire [31:0] cfg = cfg_q[c][s];
         wire en = cfg[`CFG_EN];
         wire [1:0] dir = cfg[`CFG_DIR +: 2];
         wire direct = ~fc_q[c][s][`FC_FIFOMODE];
         wire [LW-1:0] lvl = lvl_q[c][s];
         wire [LW-1:0] thr = LW'((32'(fc_q[c][s][`FC_FTH +: 2]) + 1) * FD / 4);
         wire [NCH-1:0] rq = PREQ_IN[(c * NS + s) * NCH +: NCH];
         wire req = rq[cfg[`CFG_CHSEL +: 3]];
         wire rmore = rleft_q[c][s] != 16'h0;
         wire ev = done[c] && es_q[c] == 3'(s);
         wire evr = ev & ~ew_q[c] & ~err[c];
         wire evw = ev & ew_q[c] & ~err[c];
         wire pside = ew_q[c] ? evw && dir == `DIR_M2P : evr && dir == `DIR_P2M;
         wire cw = wr_acc && ctl_ok && ac == c && dcd[6] && dcd[5:3] == 3'(s);
         wire [31:0] wv = (cfg_q[c][s] & ~wmask) | (AVS_WRITEDATA_IN & wmask);
         wire [31:0] wd = AVS_WRITEDATA_IN & wmask;
         wire hsel = s >= 4;
         wire [9:0] clr_off = hsel ? `OFF_HCLR : `OFF_LCLR;
         wire [9:0] set_off = hsel ? `OFF_HSET : `OFF_LSET;
         wire [4:0] fp = fpos(2'(s % 4));
         wire fwr = wr_acc && ctl_ok && ac == c;
         wire [5:0] fclr = (fwr && off == clr_off) ? wd[fp +: 6] : 6'h0;
         wire [5:0] fset = (fwr && off == set_off) ? wd[fp +: 6] & 6'h3d : 6'h0;
         wire try = cw && dcd[2:0] == `FLD_CFG && !en && wv[`CFG_EN];
         wire [1:0] wdir = wv[`CFG_DIR +: 2];
         wire dir_bad = wdir == 2'h3 || (wdir == `DIR_M2M && c == 0);
         wire dm_bad = wv[`CFG_PSIZE +: 2] != wv[`CFG_MSIZE +: 2] || wdir == `DIR_M2M ||
                       wv[`CFG_PBURST +: 2] != 2'h0 || wv[`CFG_MBURST +: 2] != 2'h0;
         wire fe_bad = (wv[`CFG_PBURST +: 2] != 2'h0 && !wv[`CFG_PINC]) ||
                       (wv[`CFG_MBURST +: 2] != 2'h0 && !wv[`CFG_MINC]);
         wire bad = dir_bad | (direct ? dm_bad : fe_bad);
         wire last = nleft_q[c][s] == 16'h1;
         wire [15:0] nl1 = nleft_q[c][s] - 16'h1;
         wire [5:0] hw = {evw & last, evw & (nl1 == (nini_q[c][s] >> 1)), (ev & err[c]) |
                          (try & dir_bad), try & direct & dm_bad & ~dir_bad, 1'b0,
                          try & ~direct & fe_bad & ~dir_bad};
         wire src_mem = dir == `DIR_M2P;
         wire [31:0] pstep = cfg[`CFG_PINC] ? 32'h1 << cfg[`CFG_PSIZE +: 2] : 32'h0;
         wire [31:0] mstep = cfg[`CFG_MINC] ? 32'h1 << cfg[`CFG_MSIZE +: 2] : 32'h0;

         assign prs[2 * s +: 2] = cfg[`CFG_PRIO +: 2];
         always_comb begin
            want[s] = 1'b0;
            wwr[s] = 1'b0;
            if (en) begin
               case (dir)
                  `DIR_P2M: begin
                     wwr[s] = direct ? lvl != 0 : lvl >= thr || (!rmore && lvl != 0);
                     want[s] = wwr[s] || (pend_q[c][s] && rmore &&
                               (direct ? lvl == 0 : 32'(lvl) < FD));
                  end
                  `DIR_M2P: begin
                     wwr[s] = pend_q[c][s] && lvl != 0;
                     want[s] = wwr[s] || (rmore && (direct ? lvl == 0 : 32'(lvl) < FD));
                  end
                  `DIR_M2M: begin
                     wwr[s] = lvl >= thr || (!rmore && lvl != 0);
                     want[s] = wwr[s] || (rmore && 32'(lvl) < FD);
                  end
                  default: want[s] = 1'b0;
               endcase
            end
         end

         always_ff @(posedge CLK_IN) begin
            if (evr) fifo_q[c][s][wp_q[c][s]] <= rdv[c];
         end

         always_ff @(posedge CLK_IN or negedge NRST_IN) begin
            if (!NRST_IN) begin
               cfg_q[c][s] <= `REG_RST;
               fc_q[c][s] <= `REG_RST;
               pbase_q[c][s] <= `REG_RST;
               mbase_q[c][s] <= `REG_RST;
               pcur_q[c][s] <= `REG_RST;
               mcur_q[c][s] <= `REG_RST;
               nini_q[c][s] <= 16'h0;
               nleft_q[c][s] <= 16'h0;
               rleft_q[c][s] <= 16'h0;
               lvl_q[c][s] <= '0;
               wp_q[c][s] <= '0;
               rp_q[c][s] <= '0;
               flg_q[c][s] <= 6'h0;
               pend_q[c][s] <= 1'b0;
               prev_q[c][s] <= 1'b0;
               PACK_OUT[c * NS + s] <= 1'b0;
            end else begin
               prev_q[c][s] <= req;
               PACK_OUT[c * NS + s] <= pside;
               pend_q[c][s] <= (req & ~prev_q[c][s]) | (pend_q[c][s] & ~pside);
               flg_q[c][s] <= (flg_q[c][s] & ~fclr) | fset | hw;
               if (cw && en && dcd[2:0] == `FLD_CFG) cfg_q[c][s][`CFG_EN] <= wv[`CFG_EN];
               if (cw && !en) begin
                  case (dcd[2:0])
                     `FLD_CFG: cfg_q[c][s] <= wv & `CFG_MASK & ~(32'(bad) << `CFG_EN);
                     `FLD_NDATA: begin
                        nini_q[c][s] <= wv[15:0];
                        nleft_q[c][s] <= wv[15:0];
                     end
                     `FLD_PADDR: pbase_q[c][s] <= wv;
                     `FLD_MADDR: mbase_q[c][s] <= wv;
                     `FLD_FCTRL: fc_q[c][s] <= wv & `FC_MASK;
                     default: ;
                  endcase
               end
               if (try && !bad) begin
                  pcur_q[c][s] <= pbase_q[c][s];
                  mcur_q[c][s] <= mbase_q[c][s];
                  nleft_q[c][s] <= nini_q[c][s];
                  rleft_q[c][s] <= nini_q[c][s];
                  lvl_q[c][s] <= '0;
                  wp_q[c][s] <= '0;
                  rp_q[c][s] <= '0;
               end
               if (ev && err[c]) cfg_q[c][s][`CFG_EN] <= 1'b0;
               if (evr) begin
                  wp_q[c][s] <= wp_q[c][s] + PW'(1);
                  lvl_q[c][s] <= lvl + LW'(1);
                  rleft_q[c][s] <= rleft_q[c][s] - 16'h1;
                  if (src_mem) mcur_q[c][s] <= mcur_q[c][s] + mstep;
                  else pcur_q[c][s] <= pcur_q[c][s] + pstep;
               end
               if (evw) begin
                  rp_q[c][s] <= rp_q[c][s] + PW'(1);
                  lvl_q[c][s] <= lvl - LW'(1);
                  nleft_q[c][s] <= nl1;
                  if (src_mem) pcur_q[c][s] <= pcur_q[c][s] + pstep;
                  else mcur_q[c][s] <= mcur_q[c][s] + mstep;
                  if (last && cfg[`CFG_CIRC]) begin
                     nleft_q[c][s] <= nini_q[c][s];
                     rleft_q[c][s] <= nini_q[c][s];
                     pcur_q[c][s] <= pbase_q[c][s];
                     mcur_q[c][s] <= mbase_q[c][s];
                  end else if (last) begin
                     cfg_q[c][s][`CFG_EN] <= 1'b0;
                  end
               end
            end
         end

         fifo_cap_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            32'(lvl) <= FD) else $error("fifo level above depth");
         direct_one_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            (en && direct) |-> lvl <= LW'(1)) else $error("direct mode held two items");
         direct_cfg_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            (en && direct) |-> cfg[`CFG_PSIZE +: 2] == cfg[`CFG_MSIZE +: 2] &&
            dir != `DIR_M2M && cfg[`CFG_MBURST +: 2] == 2'h0) else $error("bad direct setup");
         burst_inc_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            (en && cfg[`CFG_PBURST +: 2] != 2'h0) |-> cfg[`CFG_PINC]) else $error("burst w/o inc");
         ctl_dir_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            en |-> dir != 2'h3 && (c != 0 || dir != `DIR_M2M)) else $error("illegal direction");
         ack_req_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            PACK_OUT[c * NS + s] |-> $past(pend_q[c][s])) else $error("ack without request");
         circ_load_a: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
            (evw && last) |=> (nleft_q[c][s] == nini_q[c][s]) == $past(cfg[`CFG_CIRC]) ||
            nini_q[c][s] == 16'h0) else $error("circular reload wrong");
      end
   end
endmodule : dma_stream_core

// [verilog/dma_cfg.svh]
`ifndef DMA_CFG_SVH
`define DMA_CFG_SVH
// register offsets inside one controller window
`define OFF_LSTS 10'h000
`define OFF_HSTS 10'h004
`define OFF_LCLR 10'h008
`define OFF_HCLR 10'h00c
`define OFF_STRM0 10'h010
`define STRM_STRIDE 10'h018
`define OFF_LSET 10'h0d0
`define OFF_HSET 10'h0d4
// stream register field index within a stream block
`define FLD_CFG 3'd0
`define FLD_NDATA 3'd1
`define FLD_PADDR 3'd2
`define FLD_MADDR 3'd3
`define FLD_FCTRL 3'd5
// stream_config_register fields
`define CFG_EN 0
`define CFG_DIR 6
`define CFG_CIRC 8
`define CFG_PINC 9
`define CFG_MINC 10
`define CFG_PSIZE 11
`define CFG_MSIZE 13
`define CFG_PRIO 16
`define CFG_PBURST 21
`define CFG_MBURST 23
`define CFG_CHSEL 25
`define CFG_MASK 32'h0fe37fc1
// fifo control fields
`define FC_FTH 0
`define FC_FIFOMODE 2
`define FC_LVL 3
`define FC_MASK 32'h00000007
// per-stream flag bits
`define FLG_FE 0
`define FLG_DME 2
`define FLG_TXE 3
`define FLG_HT 4
`define FLG_TC 5
`define REG_RST 32'h00000000
`define DIR_P2M 2'h0
`define DIR_M2P 2'h1
`define DIR_M2M 2'h2
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`endif

// [verilog/dma_pkg.sv]
// Purpose: types shared by the stream dma core
// Assumes: ahb-lite single-beat masters
// Notes: constants live in dma_cfg.svh
package dma_pkg;
   typedef struct packed {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
   } ahb_m_t;
   typedef struct packed {
      logic [31:0] hrdata;
      logic hready;
      logic hresp;
   } ahb_s_t;
   typedef enum logic [1:0] {E_IDLE, E_ADDR, E_DATA} eng_state_t;
endpackage : dma_pkg

// [testbench/ahb_slave_model.sv]
// Purpose: ahb-lite slave standing on one dma master port
// Assumes: single beats, hsize ignored, word-addressed memory
// Notes: WAIT stretches every data phase to act as a slow slave
`timescale 1ns/1ps
`include "dma_cfg.svh"
module ahb_slave_model import dma_pkg::*; #(
   parameter int WAIT = 0
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire ahb_m_t m_in,
   output ahb_s_t s_out
);
   logic [31:0] mem [0:255];
   logic busy_q;
   logic wr_q;
   logic tog_q;
   logic [7:0] wa_q;
   int cnt_q;
   wire done = busy_q && cnt_q == 0;
   assign s_out.hready = !busy_q || done;
   assign s_out.hresp = 1'b0;
   // outside a data phase the lines toggle, so stale data never looks valid
   assign s_out.hrdata = done ? mem[wa_q] : {16{tog_q, !tog_q}};
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         busy_q <= 1'b0;
         cnt_q <= 0;
         tog_q <= 1'b0;
      end else begin
         tog_q <= !tog_q;
         if (done) begin
            busy_q <= 1'b0;
            if (wr_q) mem[wa_q] <= m_in.hwdata;
         end else if (busy_q) cnt_q <= cnt_q - 1;
         // data moves only for a beat the master has issued
         if (m_in.htrans == `HTRANS_NONSEQ && s_out.hready) begin
            busy_q <= 1'b1;
            cnt_q <= WAIT;
            wr_q <= m_in.hwrite;
            wa_q <= m_in.haddr[9:2];
         end
      end
   end
endmodule : ahb_slave_model

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the stream dma core
// Assumes: slave models on all ports, direct mode after reset
// Notes: requests are short pulses on the one selected channel line; t_prio holds both of its lines high until the first ack
`timescale 1ns/1ps
`include "dma_cfg.svh"
module tb_top import dma_pkg::*;;
   logic clk;
   logic nrst;
   logic rd;
   logic wr;
   logic [10:0] adr;
   logic [31:0] wd;
   logic [31:0] rdat;
   logic wait_rq;
   logic [127:0] preq;
   logic [15:0] pack;
   ahb_m_t [1:0] mm;
   ahb_s_t [1:0] ms;
   ahb_m_t [1:0] pm;
   ahb_s_t [1:0] ps;
   int num_errors = 0;
   int checks = 0;
   dma_stream_core u_dma_stream_core (.CLK_IN(clk), .NRST_IN(nrst), .AVS_ADDRESS_IN(adr),
      .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf),
      .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(wait_rq), .PREQ_IN(preq),
      .PACK_OUT(pack), .MEM_M_OUT(mm), .MEM_S_IN(ms), .PER_M_OUT(pm), .PER_S_IN(ps));
   for (genvar c = 0; c < 2; c++) begin : g
      ahb_slave_model #(.WAIT(2)) mem_s (.clk_in(clk), .nrst_in(nrst), .m_in(mm[c]),
         .s_out(ms[c]));
      ahb_slave_model #(.WAIT(0)) per_s (.clk_in(clk), .nrst_in(nrst), .m_in(pm[c]),
         .s_out(ps[c]));
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = !clk;
   end
   task automatic finish_test;
      if (num_errors == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [10:0] a, input logic [31:0] d,
         output logic [31:0] q);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
         n++;
      end while (wait_rq !== 1'b0 && n < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         finish_test();
      end else begin
         @(posedge clk);
      end
   endtask : bus
   task automatic wreg(input logic [10:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wreg
   task automatic rreg(input logic [10:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask : rreg
   function automatic logic [10:0] sra(input int c, input int s, input int f);
      return {c[0], 10'(`OFF_STRM0 + `STRM_STRIDE * s + 4 * f)};
   endfunction : sra
   function automatic logic [31:0] cfg(input int dr, input int pi, input int mi,
         input int sp, input int sm, input int pr, input int ch, input int pb);
      return 32'(1 | dr << `CFG_DIR | pi << `CFG_PINC | mi << `CFG_MINC | sp << `CFG_PSIZE
         | sm << `CFG_MSIZE | pr << `CFG_PRIO | ch << `CFG_CHSEL | pb << `CFG_PBURST);
   endfunction : cfg
   task automatic wack(input int i);
      int n;
      n = 0;
      while (pack[i] !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      if (n >= 100) begin
         num_errors++;
         finish_test();
      end
   endtask : wack
   task automatic mchk(input int i, input logic [31:0] e);
      int n;
      n = 0;
      while (g[1].mem_s.mem[i] !== e && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(g[1].mem_s.mem[i], e);
      if (n >= 100) finish_test();
   endtask : mchk
   task automatic t_regs;
      rreg(sra(0, 3, 0), 32'h0, '1);
      rreg(11'h3fc, 32'h0, '1);
      wreg(11'h4d4, 32'h3f);
      rreg(11'h404, 32'h3d, '1);
      wreg(11'h40c, '1);
      rreg(11'h404, 32'h0, '1);
   endtask : t_regs
   task automatic t_p2m;
      g[1].per_s.mem[16] = 32'ha1b2c3d4;
      g[1].per_s.mem[17] = 32'h5e6f7081;
      wreg(sra(1, 2, 1), 32'h2);
      wreg(sra(1, 2, 2), 32'h40);
      wreg(sra(1, 2, 3), 32'h100);
      wreg(sra(1, 2, 0), cfg(0, 1, 1, 2, 2, 0, 5, 0));
      repeat (2) begin
         preq[64 + 16 + 5] <= 1'b1;
         @(posedge clk);
         preq[64 + 16 + 5] <= 1'b0;
         wack(10);
      end
      mchk(8'h40, 32'ha1b2c3d4);
      mchk(8'h41, 32'h5e6f7081);
      rreg(sra(1, 2, 1), 32'h0, '1);
      rreg(11'h400, 32'h0030_0000, '1);
   endtask : t_p2m
   task automatic t_bad;
      logic [31:0] cw[4];
      int cc[4] = '{0, 1, 1, 1};
      logic [31:0] fc[4] = '{32'h4, 32'h4, 32'h0, 32'h4};
      int fb[4] = '{3, 3, 2, 0};
      // m2m on first controller, reserved dir, width mismatch, burst without increment
      cw = '{cfg(2, 1, 1, 2, 2, 0, 0, 0), cfg(3, 1, 1, 2, 2, 0, 0, 0),
         cfg(0, 1, 1, 2, 0, 0, 0, 0), cfg(0, 0, 1, 2, 2, 0, 0, 1)};
      for (int i = 0; i < 4; i++) begin
         wreg(sra(cc[i], 0, 5), fc[i]);
         wreg(sra(cc[i], 0, 0), cw[i]);
         rreg(sra(cc[i], 0, 0), 32'h0, 32'h1);
         rreg({cc[i][0], 10'h0}, 32'h1 << fb[i], 32'h3d);
         wreg({cc[i][0], 10'h8}, '1);
      end
   endtask : t_bad
   task automatic arm(input int s, input int pr);
      wreg(sra(1, s, 1), 32'h1);
      wreg(sra(1, s, 2), 32'h80);
      wreg(sra(1, s, 3), 32'h200);
      wreg(sra(1, s, 0), cfg(0, 0, 0, 2, 2, pr, s, 0));
   endtask : arm
   task automatic t_prio(input int sa, input int pa, input int sb, input int pb, input int w);
      int n;
      arm(sa, pa);
      arm(sb, pb);
      preq[64 + 9 * sa] <= 1'b1;
      preq[64 + 9 * sb] <= 1'b1;
      n = 0;
      while (pack[15:8] === 8'h0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(pack[15:8]), 32'h1 << w);
      if (n >= 100) finish_test();
      preq <= '0;
      wack(8 + sa + sb - w);
   endtask : t_prio
   // fifo mode, half threshold, half-word source into word destination
   task automatic t_fifo;
      g[1].per_s.mem[32] = 32'h1234abcd;
      g[1].mem_s.mem[192] = 32'h0;
      wreg(sra(1, 1, 1), 32'h2);
      wreg(sra(1, 1, 2), 32'h80);
      wreg(sra(1, 1, 3), 32'h300);
      wreg(sra(1, 1, 5), 32'h5);
      wreg(sra(1, 1, 0), cfg(0, 1, 1, 1, 2, 0, 1, 0));
      for (int i = 0; i < 2; i++) begin
         preq[73] <= 1'b1;
         @(posedge clk);
         preq[73] <= 1'b0;
         wack(9);
         if (i == 0) begin
            repeat (8) @(posedge clk);
            rreg(sra(1, 1, 5), 32'hd, '1);
            chk(g[1].mem_s.mem[192], 32'h0);
         end
      end
      mchk(192, 32'h0000abcd);
      mchk(193, 32'h00001234);
   endtask : t_fifo
   // direct memory-to-peripheral: item fetched before the request arrives
   task automatic t_pre;
      g[1].mem_s.mem[0] = 32'h5a5a0f0f;
      g[1].per_s.mem[48] = 32'h0;
      wreg(sra(1, 7, 1), 32'h1);
      wreg(sra(1, 7, 2), 32'hc0);
      wreg(sra(1, 7, 3), 32'h0);
      wreg(sra(1, 7, 0), cfg(1, 0, 0, 2, 2, 0, 7, 0));
      repeat (12) @(posedge clk);
      rreg(sra(1, 7, 5), 32'h8, '1);
      chk(g[1].per_s.mem[48], 32'h0);
      preq[127] <= 1'b1;
      @(posedge clk);
      preq[127] <= 1'b0;
      wack(15);
      chk(g[1].per_s.mem[48], 32'h5a5a0f0f);
   endtask : t_pre
   initial begin
      nrst = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = '0;
      wd = '0;
      preq = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_p2m();
      t_bad();
      t_prio(5, 0, 6, 3, 6);
      t_prio(4, 2, 3, 2, 3);
      t_fifo();
      t_pre();
      finish_test();
   end
endmodule : tb_top
